// ==== icp_bus_if.sv ====
`timescale 1ns/1ps
interface icp_bus_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic rst_n;
  logic scl;
  logic sda;
  // Open-drain wired AND with pull-ups
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~(sda_m_oe & ~sda_m_o) & ~(sda_s_oe & ~sda_s_o);
  modport dev (input scl, input sda, input rst_n, output sda_s_o, output sda_s_oe);
  modport mst (input scl, input sda, output scl_o, output scl_oe, output sda_m_o, output sda_m_oe, output rst_n);
endinterface : icp_bus_if

// ==== icp_chk.sv ====
`timescale 1ns/1ps
module icp_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic rst_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  a_slave_low_only: assert property (sda_s_oe |-> !sda_s_o)
    else $error("slave drives data high");
  a_master_low_only: assert property (sda_m_oe |-> !sda_m_o)
    else $error("master drives data high");
  a_clock_low_only: assert property (scl_oe |-> !scl_o)
    else $error("master drives clock high");
  a_clock_from_master: assert property (!scl |-> scl_oe)
    else $error("clock low without master drive");
  a_quiet_in_reset: assert property (!rst_n |-> !sda_s_oe)
    else $error("slave drives data while held in reset");
  a_slave_change_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave data changed while clock high");
  a_slave_drive_held: assert property ($rose(sda_s_oe) |=> sda_s_oe [*8])
    else $error("slave drive too short");
  a_idle_after_stop: assert property (scl && $rose(sda) |=> !sda_s_oe [*4])
    else $error("slave drives data after stop");
  c_slave_ack: cover property ($rose(sda_s_oe));
  c_start: cover property (scl && $fell(sda));
  c_stop: cover property (scl && $rose(sda));
endmodule : icp_chk

// ==== icp_master.sv ====
`timescale 1ns/1ps
module icp_master
  import icp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  icp_bus_if.mst bus,
  input wire logic fast_mode,
  input wire logic cmd_valid,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_ack,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic [7:0] rsp_data,
  output logic rsp_ack,
  output logic rsp_valid
);
  typedef enum logic [2:0] {
    ICM_RST = 3'b000,
    ICM_IDLE = 3'b001,
    ICM_START = 3'b010,
    ICM_BITS = 3'b011,
    ICM_STOP = 3'b100
  } icm_state_t;
  icm_state_t state;
  logic [15:0] div;
  logic tick, ph;
  logic [3:0] bit_n;
  logic [8:0] sh;
  logic stop_after;
  logic [7:0] rst_cnt;
  // Divider tick at the half period of the chosen mode
  always_ff @(posedge clk) begin
    if (sys_rst || tick) begin
      div <= 16'h0000;
    end else begin
      div <= div + 16'h0001;
    end
  end
  assign tick = int'(div) >= (fast_mode ? FAST_HALF_CYC : STD_HALF_CYC) - 1; // RULE_05
  always_ff @(posedge clk) begin
    rsp_valid <= 1'b0;
    if (sys_rst) begin
      state <= ICM_RST;
      rst_cnt <= 8'h00;
      bus.rst_n <= 1'b0;
      bus.scl_o <= 1'b0;
      bus.scl_oe <= 1'b0;
      bus.sda_m_o <= 1'b0;
      bus.sda_m_oe <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_data <= 8'h00;
      rsp_ack <= 1'b0;
      ph <= 1'b0;
      bit_n <= 4'h0;
      sh <= 9'h000;
      stop_after <= 1'b0;
    end else begin
      unique case (state)
        ICM_RST: begin
          if (int'(rst_cnt) >= RESET_LOW_CYC) begin
            bus.rst_n <= 1'b1; // RULE_01
            state <= ICM_IDLE;
            cmd_ready <= 1'b1;
          end else begin
            rst_cnt <= rst_cnt + 8'h01;
          end
        end
        ICM_IDLE: begin
          if (cmd_valid) begin
            cmd_ready <= 1'b0;
            stop_after <= cmd_stop;
            // Receive leaves data released except our ack bit
            sh <= cmd_read ? {8'hFF, ~cmd_ack} : {cmd_data, 1'b1}; // RULE_13
            bit_n <= 4'h0;
            ph <= 1'b0;
            state <= cmd_start ? ICM_START : ICM_BITS;
          end
        end
        ICM_START: if (tick) begin
          if (bit_n == 4'h0) begin
            // Clock low first so a held acknowledge lets go
            bus.scl_oe <= 1'b1;
            bus.sda_m_oe <= 1'b0;
            bit_n <= 4'h1;
          end else if (bit_n == 4'h1) begin
            bus.scl_oe <= 1'b0;
            bit_n <= 4'h2;
          end else begin
            bus.sda_m_oe <= 1'b1; // RULE_10
            bit_n <= 4'h0;
            ph <= 1'b0;
            state <= ICM_BITS;
          end
        end
        ICM_BITS: if (tick) begin
          if (!ph) begin
            bus.scl_oe <= 1'b1; // RULE_20
            bus.sda_m_oe <= ~sh[8]; // RULE_08
            ph <= 1'b1;
          end else begin
            bus.scl_oe <= 1'b0;
            rsp_data <= {rsp_data[6:0], bus.sda};
            sh <= {sh[7:0], 1'b1};
            ph <= 1'b0;
            if (bit_n == 4'h8) begin
              rsp_ack <= ~bus.sda; // RULE_14
              rsp_data <= rsp_data;
              rsp_valid <= 1'b1;
              state <= stop_after ? ICM_STOP : ICM_IDLE;
              cmd_ready <= ~stop_after;
            end
            bit_n <= bit_n + 4'h1;
          end
        end
        ICM_STOP: if (tick) begin
          if (!ph) begin
            bus.scl_oe <= 1'b1;
            bus.sda_m_oe <= 1'b1;
            ph <= 1'b1;
          end else if (bus.scl_oe) begin
            bus.scl_oe <= 1'b0;
          end else begin
            bus.sda_m_oe <= 1'b0;
            ph <= 1'b0;
            state <= ICM_IDLE;
            cmd_ready <= 1'b1;
          end
        end
        default: state <= ICM_IDLE;
      endcase
    end
  end
endmodule : icp_master

// ==== icp_pkg.sv ====
// Contract
// RULE_01 - Master holds reset low at least 10 ns
// RULE_02 - Clocks withheld about 10 ms after PLL on
// RULE_03 - All blocks powered down after reset
// RULE_04 - Power down keeps register contents
// RULE_05 - Serial clock up to 100/400 kHz; fast mode divides to 124 cycles, about 403 kHz
// RULE_06 - Address is 00110 plus two strap bits
// RULE_07 - Device is slave only, never drives clock
// RULE_08 - Lines only pulled low, released high
// RULE_09 - Eight-bit bytes, data changes while clock low
// RULE_10 - Detect START and STOP while clock high
// RULE_11 - Match seven address bits, eighth is direction
// RULE_12 - Device acknowledges each byte addressed to it
// RULE_13 - Master acknowledges read bytes to continue
// RULE_14 - Released data line means not-acknowledge
// RULE_15 - START during transfer is repeated START
// RULE_16 - General call address 00h is acknowledged
// RULE_17 - Write bytes auto-increment register address
// RULE_18 - Acknowledged reads send next register
// RULE_19 - STOP returns interface to idle
// RULE_20 - Master generates every serial clock pulse
// RULE_21 - First write byte sets register pointer
// RULE_22 - Ignore bus while reset input low
package icp_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int RESET_LOW_NS = 10;
  localparam int RESET_LOW_CYC = (RESET_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000 < 1 ? 1 :
    (RESET_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PLL_DELAY_MS = 10;
  localparam int PLL_DELAY_CYC = PLL_DELAY_MS * (CLK_HZ / 1000);
  localparam int STD_SCL_HZ = 100_000;
  localparam int FAST_SCL_HZ = 400_000;
  localparam int STD_HALF_CYC = CLK_HZ / (2 * STD_SCL_HZ);
  localparam int FAST_HALF_CYC = CLK_HZ / (2 * FAST_SCL_HZ);
  localparam logic [4:0] DEV_ADDR_HI = 5'h06;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] PWR_RESET = 8'h00;
  localparam logic [7:0] PWR_PLL_BIT = 8'h01;
  localparam logic [7:0] PWR_REG_ADDR = 8'h01;
  localparam logic [7:0] REG_RESET = 8'h00;
endpackage : icp_pkg

// ==== icp_regfile.sv ====
`timescale 1ns/1ps
module icp_regfile
  import icp_pkg::*;
#(
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);
  if (DEPTH < 2 || DEPTH > 256) begin : g_bad_depth
    $error("icp_regfile: DEPTH out of range");
  end
  logic [7:0] mem [DEPTH];
  // Only power-on state; power down never clears contents
  genvar g;
  for (g = 0; g < DEPTH; g++) begin : g_reg
    always_ff @(posedge clk) begin
      if (wr_en && wr_addr == 8'(g)) begin
        mem[g] <= wr_data; // RULE_04
      end
    end
  end
  assign rd_data = (int'(rd_addr) < DEPTH) ? mem[rd_addr] : REG_RESET;
endmodule : icp_regfile

// ==== icp_slave.sv ====
`timescale 1ns/1ps
module icp_slave
  import icp_pkg::*;
#(
  parameter int PLL_CYC = PLL_DELAY_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  icp_bus_if.dev bus,
  input wire logic addr_strap_hi,
  input wire logic addr_strap_lo,
  output logic [7:0] pwr_ctrl,
  output logic pll_clk_ready,
  output logic busy
);
  if (PLL_CYC < 1) begin : g_bad_pll
    $error("icp_slave: PLL_CYC must be positive");
  end
  typedef enum logic [2:0] {
    ICP_IDLE = 3'b000,
    ICP_ADDR = 3'b001,
    ICP_ACK = 3'b010,
    ICP_WR = 3'b011,
    ICP_RD = 3'b100,
    ICP_RACK = 3'b101
  } icp_state_t;
  icp_state_t state;
  logic scl_q, sda_q, hw_rst, strap_hi, strap_lo;
  logic [2:0] bit_cnt;
  logic [7:0] shreg, ptr, rd_data, tx_byte;
  logic have_ptr, wr_en, rd_pend, byte_done, ptr_load;
  logic addr_hit, call_hit;
  logic [$clog2(PLL_CYC + 1)-1:0] pll_cnt;
  logic start_det, stop_det, scl_rise, scl_fall;
  logic [6:0] my_addr;
  // Either reset source holds the port silent
  assign hw_rst = sys_rst | ~bus.rst_n; // RULE_22
  assign start_det = scl_q & bus.scl & sda_q & ~bus.sda; // RULE_10
  assign stop_det = scl_q & bus.scl & ~sda_q & bus.sda; // RULE_10
  assign scl_rise = ~scl_q & bus.scl;
  assign scl_fall = scl_q & ~bus.scl;
  assign my_addr = {DEV_ADDR_HI, strap_hi, strap_lo}; // RULE_06
  // Own address, or general call for writes only
  assign addr_hit = shreg[7:1] == my_addr; // RULE_11
  assign call_hit = shreg[7:1] == GEN_CALL_ADDR && !shreg[0]; // RULE_16
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    scl_q <= bus.scl;
    sda_q <= bus.sda;
  end
  // Straps caught while held in reset
  always_ff @(posedge clk) begin
    if (hw_rst) begin
      strap_hi <= addr_strap_hi;
      strap_lo <= addr_strap_lo;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Byte engine; sampled on clock rise, driven after clock fall
  always_ff @(posedge clk) begin
    wr_en <= 1'b0;
    ptr_load <= 1'b0;
    if (hw_rst) begin
      state <= ICP_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      byte_done <= 1'b0;
      have_ptr <= 1'b0;
      ptr <= 8'h00;
      rd_pend <= 1'b0;
      bus.sda_s_oe <= 1'b0;
    end else if (start_det) begin
      state <= ICP_ADDR; // RULE_15
      bit_cnt <= 3'h0;
      byte_done <= 1'b0;
      bus.sda_s_oe <= 1'b0;
    end else if (stop_det) begin
      state <= ICP_IDLE; // RULE_19
      bus.sda_s_oe <= 1'b0;
    end else begin
      unique case (state)
        ICP_IDLE: begin
          bus.sda_s_oe <= 1'b0;
        end
        ICP_ADDR, ICP_WR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], bus.sda}; // RULE_09
            bit_cnt <= bit_cnt + 3'h1;
            // Byte boundary only after the eighth rise
            byte_done <= (bit_cnt == BIT_LAST);
          end else if (scl_fall && byte_done) begin
            byte_done <= 1'b0;
            if (state == ICP_ADDR) begin
              have_ptr <= 1'b0;
              bus.sda_s_oe <= addr_hit || call_hit; // RULE_12
              state <= (addr_hit || call_hit) ? ICP_ACK : ICP_IDLE; // RULE_14
              rd_pend <= shreg[0] && addr_hit;
            end else begin
              if (!have_ptr) begin
                ptr <= shreg; // RULE_21
                have_ptr <= 1'b1;
                ptr_load <= 1'b1;
              end else begin
                wr_en <= 1'b1;
              end
              bus.sda_s_oe <= 1'b1; // RULE_12
              state <= ICP_ACK;
            end
          end
        end
        ICP_ACK: begin
          if (scl_fall) begin
            // First read byte leaves on the fall ending the slot
            bus.sda_s_oe <= 1'b0;
            if (rd_pend) begin
              state <= ICP_RD;
              tx_byte <= rd_data;
              bus.sda_s_oe <= ~rd_data[7]; // RULE_08
              bit_cnt <= 3'h0;
            end else begin
              state <= ICP_WR;
            end
          end
        end
        // Bits shifted out MSB first on each fall
        ICP_RD: begin
          if (scl_fall) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == BIT_LAST) begin
              bus.sda_s_oe <= 1'b0;
              state <= ICP_RACK;
            end else begin
              bus.sda_s_oe <= ~tx_byte[3'(BIT_LAST - bit_cnt - 3'h1)]; // RULE_09
            end
          end
        end
        ICP_RACK: begin
          if (scl_rise) begin
            rd_pend <= ~bus.sda; // RULE_13
            if (!bus.sda) begin
              ptr <= ptr + 8'h01; // RULE_18
            end
          end else if (scl_fall) begin
            // Next byte leaves on the fall that ends the slot
            bit_cnt <= 3'h0;
            if (rd_pend) begin
              state <= ICP_RD; // RULE_18
              tx_byte <= rd_data;
              bus.sda_s_oe <= ~rd_data[7]; // RULE_09
            end else begin
              state <= ICP_IDLE; // RULE_14
            end
          end
        end
        default: state <= ICP_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  // Pointer advance after each stored byte
  logic [7:0] wr_addr_q;
  always_ff @(posedge clk) begin
    if (hw_rst) begin
      wr_addr_q <= 8'h00;
    end else if (wr_en) begin
      wr_addr_q <= wr_addr_q + 8'h01; // RULE_17
    end else if (ptr_load) begin
      wr_addr_q <= ptr; // RULE_21
    end
  end
  icp_regfile u_regs (
    .clk(clk),
    .wr_en(wr_en),
    .wr_addr(wr_addr_q),
    .wr_data(shreg),
    .rd_addr(ptr),
    .rd_data(rd_data)
  );
  // Slave only: never drives the clock; data line driven low only
  assign bus.sda_s_o = 1'b0; // RULE_07
  ////////////////////////////////////////////////////////////////
  // Power control mirror and PLL start-up delay
  always_ff @(posedge clk) begin
    if (hw_rst) begin
      pwr_ctrl <= PWR_RESET; // RULE_03
    end else if (wr_en && wr_addr_q == PWR_REG_ADDR) begin
      pwr_ctrl <= shreg;
    end
  end
  always_ff @(posedge clk) begin
    if (hw_rst || (pwr_ctrl & PWR_PLL_BIT) == 8'h00) begin
      pll_cnt <= '0;
      pll_clk_ready <= 1'b0;
    end else if (int'(pll_cnt) < PLL_CYC) begin
      pll_cnt <= pll_cnt + 1'b1; // RULE_02
    end else begin
      pll_clk_ready <= 1'b1; // RULE_02
    end
  end
  // Busy while a transfer is open
  always_ff @(posedge clk) begin
    if (hw_rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state != ICP_IDLE);
    end
  end
endmodule : icp_slave

// ==== icp_tb.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module i2c_control_slave_port_tb;
  import icp_pkg::*;
  typedef struct packed {
    logic s;
    logic p;
    logic r;
    logic a;
    logic [7:0] d;
    logic exp_ack;
    logic [7:0] exp_d;
  } icp_row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic fast_mode = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_start = 1'b0;
  logic cmd_stop = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_ack = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready;
  logic [7:0] rsp_data;
  logic rsp_ack;
  logic rsp_valid;
  logic [7:0] pwr_ctrl;
  logic pll_clk_ready;
  logic busy;
  int num_errors = 0;
  int compares = 0;
  icp_row_t rows [0:10];
  always #10 clk = ~clk;
  icp_bus_if bus ();
  icp_slave #(.PLL_CYC(20)) icp_slave_i (.clk(clk), .sys_rst(sys_rst), .bus(bus.dev), .addr_strap_hi(1'b1),
    .addr_strap_lo(1'b0), .pwr_ctrl(pwr_ctrl), .pll_clk_ready(pll_clk_ready), .busy(busy));
  icp_master icp_master_i (.clk(clk), .sys_rst(sys_rst), .bus(bus.mst), .fast_mode(fast_mode),
    .cmd_valid(cmd_valid), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_ack(cmd_ack),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_ack(rsp_ack), .rsp_valid(rsp_valid));
  icp_chk icp_chk_i (.clk(clk), .sys_rst(sys_rst), .scl(bus.scl), .sda(bus.sda), .scl_o(bus.scl_o),
    .scl_oe(bus.scl_oe), .sda_m_o(bus.sda_m_o), .sda_m_oe(bus.sda_m_oe), .sda_s_o(bus.sda_s_o),
    .sda_s_oe(bus.sda_s_oe), .rst_n(bus.rst_n));
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // One byte on the bus, waits for its response
  task automatic xfer(input logic s, input logic p, input logic r, input logic a, input logic [7:0] d);
    @(posedge clk);
    cmd_start <= s;
    cmd_stop <= p;
    cmd_read <= r;
    cmd_ack <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1) @(posedge clk);
  endtask : xfer
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    while (cmd_ready !== 1'b1) @(posedge clk);
  endtask : do_reset
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    // Strap pins 1,0 give address 0011010
    rows[0] = '{1'b1, 1'b0, 1'b0, 1'b0, 8'h34, 1'b1, 8'h34};
    rows[1] = '{1'b0, 1'b0, 1'b0, 1'b0, 8'h10, 1'b1, 8'h10};
    rows[2] = '{1'b0, 1'b0, 1'b0, 1'b0, 8'hA5, 1'b1, 8'hA5};
    rows[3] = '{1'b0, 1'b1, 1'b0, 1'b0, 8'h5A, 1'b1, 8'h5A};
    rows[4] = '{1'b1, 1'b0, 1'b0, 1'b0, 8'h34, 1'b1, 8'h34};
    rows[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 8'h10, 1'b1, 8'h10};
    rows[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 8'h35, 1'b1, 8'h35};
    rows[7] = '{1'b0, 1'b0, 1'b1, 1'b1, 8'hFF, 1'b1, 8'hA5};
    rows[8] = '{1'b0, 1'b1, 1'b1, 1'b0, 8'hFF, 1'b0, 8'h5A};
    rows[9] = '{1'b1, 1'b1, 1'b0, 1'b0, 8'h36, 1'b0, 8'h36};
    rows[10] = '{1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 1'b1, 8'h00};
    do_reset();
    `CHK(pwr_ctrl, PWR_RESET)
    `CHK(pll_clk_ready, 1'b0)
    for (int i = 0; i <= 10; i++) begin
      xfer(rows[i].s, rows[i].p, rows[i].r, rows[i].a, rows[i].d);
      `CHK(rsp_ack, rows[i].exp_ack)
      `CHK(rsp_data, rows[i].exp_d)
      if (rows[i].p) begin
        repeat (2) @(posedge clk);
        while (cmd_ready !== 1'b1) @(posedge clk);
        repeat (4) @(posedge clk);
        `CHK(busy, 1'b0)
      end
    end
    // Power the PLL up, then down again
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h34);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, PWR_REG_ADDR);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, PWR_PLL_BIT);
    `CHK(pwr_ctrl, PWR_PLL_BIT)
    repeat (30) @(posedge clk);
    `CHK(pll_clk_ready, 1'b1)
    // Standard rate power down, settings kept
    fast_mode <= 1'b0;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h34);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, PWR_REG_ADDR);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, PWR_RESET);
    `CHK(rsp_ack, 1'b1)
    `CHK(pwr_ctrl, PWR_RESET)
    fast_mode <= 1'b1;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h34);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h11);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h35);
    xfer(1'b0, 1'b1, 1'b1, 1'b0, 8'hFF);
    `CHK(rsp_data, 8'h5A)
    // Second reset mid-run powers blocks down
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h34);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, PWR_REG_ADDR);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, PWR_PLL_BIT);
    `CHK(pwr_ctrl, PWR_PLL_BIT)
    do_reset();
    `CHK(pwr_ctrl, PWR_RESET)
    `CHK(pll_clk_ready, 1'b0)
    print_verdict();
  end
endmodule : i2c_control_slave_port_tb
